// File: slc_pkg.sv
package slc_pkg;

	// register indices on the plain port, one 16-bit register each
	localparam logic [4:0] ADDR_BASE_SEL   = 5'h00;
	localparam logic [4:0] ADDR_AMP_PCT    = 5'h01;
	localparam logic [4:0] ADDR_JUMP_PCT   = 5'h02;
	localparam logic [4:0] ADDR_PERIOD     = 5'h03;
	localparam logic [4:0] ADDR_RISE_COEF  = 5'h04;
	localparam logic [4:0] ADDR_TARGET_LEN = 5'h05;
	localparam logic [4:0] ADDR_MEAS_LEN   = 5'h06;
	localparam logic [4:0] ADDR_PPM        = 5'h07;
	localparam logic [4:0] ADDR_FINAL_THR  = 5'h08;
	localparam logic [4:0] ADDR_INTERIM    = 5'h09;
	localparam logic [4:0] ADDR_CTRL       = 5'h0a;
	localparam logic [4:0] ADDR_COUNT      = 5'h0b;
	localparam logic [4:0] ADDR_IRQ_STAT   = 5'h0c;
	localparam logic [4:0] ADDR_IRQ_CLR    = 5'h0d;
	localparam logic [4:0] ADDR_IRQ_EN     = 5'h0e;
	localparam logic [4:0] ADDR_FREQ_UPPER = 5'h0f;
	localparam logic [4:0] ADDR_FREQ_LOWER = 5'h10;
	localparam logic [4:0] ADDR_FREQ_MAX   = 5'h11;
	localparam logic [4:0] ADDR_OUT_FREQ   = 5'h12;

	// values after reset (percent in 0.1 %, time in 0.1 s, freq 0.01 Hz)
	localparam logic [15:0] RST_BASE_SEL   = 16'h0000;
	localparam logic [15:0] RST_AMP_PCT    = 16'h0000;
	localparam logic [15:0] RST_JUMP_PCT   = 16'h0000;
	localparam logic [15:0] RST_PERIOD     = 16'h0064;
	localparam logic [15:0] RST_RISE_COEF  = 16'h01f4;
	localparam logic [15:0] RST_TARGET_LEN = 16'h03e8;
	localparam logic [15:0] RST_PPM        = 16'h03e8;
	localparam logic [15:0] RST_FINAL_THR  = 16'h03e8;
	localparam logic [15:0] RST_INTERIM    = 16'h03e8;
	localparam logic [15:0] RST_CTRL       = 16'h0000;
	localparam logic [15:0] RST_FREQ_UPPER = 16'h1388;
	localparam logic [15:0] RST_FREQ_LOWER = 16'h0000;
	localparam logic [15:0] RST_FREQ_MAX   = 16'h1388;

	// field positions
	localparam int CTRL_SWING_EN = 0;
	localparam int IRQ_LEN       = 0;
	localparam int IRQ_FINAL     = 1;
	localparam int IRQ_INTERIM   = 2;
	localparam int IRQ_CYCLE     = 3;
	localparam int IRQ_W         = 4;

	// scale constants
	localparam logic [31:0] PCT_FULL    = 32'h0000_03e8; // 100.0 % in 0.1 %
	localparam logic [31:0] MS_PER_UNIT = 32'h0000_0064; // 0.1 s in ms
	localparam logic [31:0] PPM_STEP    = 32'h0000_000a; // one pulse, x10

	// swing time tick: 1 ms, fine enough for 0.1 s period steps
	localparam int CLK_NS          = 20;
	localparam int TICK_NS         = 1000000;
	localparam int TICK_CYCLES_DEF = TICK_NS / CLK_NS;

	typedef enum logic [1:0]
	{
		SLC_RISE = 2'b01,
		SLC_FALL = 2'b10
	} slc_phase_e;

	// register port request
	typedef struct packed
	{
		logic        wr;
		logic        rd;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} slc_bus_s;

	// discrete terminals in
	typedef struct packed
	{
		logic len_pulse;
		logic len_clear;
		logic cnt_pulse;
		logic cnt_clear;
	} slc_din_s;

	// software settings
	typedef struct packed
	{
		logic [15:0]       base_sel;
		logic [15:0]       amp;
		logic [15:0]       jump;
		logic [15:0]       period;
		logic [15:0]       rise;
		logic [15:0]       target;
		logic [15:0]       ppm;
		logic [15:0]       final_thr;
		logic [15:0]       interim_thr;
		logic [15:0]       ctrl;
		logic [15:0]       upper;
		logic [15:0]       lower;
		logic [15:0]       fmax;
		logic [IRQ_W-1:0]  irq_en;
	} slc_cfg_s;

	// whole module state
	typedef struct packed
	{
		slc_cfg_s          cfg;
		slc_phase_e        phase;
		logic [31:0]       tick_cnt;
		logic [31:0]       t;
		logic [31:0]       err;
		logic signed [17:0] offset;
		logic              len_d;
		logic              cnt_d;
		logic [31:0]       len_acc;
		logic [15:0]       length;
		logic [15:0]       count;
		logic              len_hit;
		logic              fin_hit;
		logic              int_hit;
		logic [IRQ_W-1:0]  irq_st;
		logic              irq;
		logic [15:0]       rdata;
		logic [15:0]       freq;
	} slc_state_s;

endpackage : slc_pkg

// File: slc_swing_length_count.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - triangular swing around set frequency
// - zero amplitude percent gives no swing
// - base 0 scales central frequency
// - base 1 scales maximum output frequency
// - jump step is amplitude times jump percent
// - clamp output between lower and upper limit
// - one swing cycle per configured period
// - rise share is period times coefficient
// - length is pulses divided by scale
// - length flag once length exceeds target
// - length clear input zeroes measured length
// - final threshold sets flag, stops counting
// - interim threshold sets flag, keeps counting
module slc_swing_length_count
	import slc_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF // cycles per swing tick
)
(
	input  wire logic        clk,            // 50 MHz clock
	input  wire logic        srst,           // sync reset, active high
	input  wire logic        ce,             // clock enable, freezes all
	input  wire slc_bus_s    bus,            // register port request
	output logic [15:0]      rdata,          // read data, cycle after rd
	input  wire logic [15:0] set_freq,       // central frequency, 0.01 Hz
	input  wire slc_din_s    din,            // discrete terminals
	output logic [15:0]      out_freq,       // swung output frequency
	output logic             length_reached, // length reached terminal
	output logic             count_final,    // final count reached
	output logic             count_interim,  // interim count reached
	output logic             irq             // level interrupt
);

	slc_state_s st;     // registered state
	slc_state_s nxt_st; // next state

	// how the block is split up
	// - one packed state word, filled by one combinational process and
	//   registered by one clocked process, so ce freezes every bit at once
	// - the swing part works in 0.01 Hz units on a signed offset that is
	//   added to the set frequency and then clamped into the limits
	// - the length part keeps a remainder in tenths of a pulse, so a
	//   fractional pulses-per-metre scale needs no divider
	// - the count part stops at the final threshold and keeps its flags
	//   until the count clear input is seen
	// - all flags also set sticky status bits for the level interrupt
	//
	// limitations a user must know
	// - the offset moves at most one unit per clock; with the real 1 ms
	//   tick that is far faster than any slope the settings can ask for,
	//   but a shortened tick in simulation can make a ramp fall short
	//   of its end point, which the turn-round value then makes up
	// - the set frequency is taken as a level; a step in it shows on the
	//   output one cycle later, clamped like the swing
	// - interim above final is not refused here: the final threshold
	//   stops the count first, so the interim flag would never rise
	//
	// hazards avoided
	// - the offset is signed and the amplitude is not: every compare of
	//   the two casts the amplitude to signed first, else a negative
	//   offset reads as a huge number and the ramp stalls at a turn
	// - pulse inputs are edge detected against their last sample, whose
	//   value after reset is the idle low of the pin, so reset never
	//   leaves a false edge behind
	// - a status event in the same cycle as its clear wins, so software
	//   never loses an event that lands while it is acknowledging
	// - read data is zero outside the cycle after a read strobe, so a
	//   stale value never looks like a fresh answer

	// derived swing figures, combinational
	logic [31:0]        base_f;   // amplitude base frequency
	logic [31:0]        aw;       // swing amplitude
	logic [31:0]        jmp;      // jump step
	logic [31:0]        per_ms;   // period in ticks
	logic [31:0]        rise_ms;  // rising ramp in ticks
	logic [31:0]        fall_ms;  // falling ramp in ticks
	logic [31:0]        seg_ms;   // current ramp length
	logic               active;   // swing running
	logic               tick;     // one-cycle swing tick
	logic signed [19:0] sum;      // centre plus offset
	logic [IRQ_W-1:0]   ev;       // events this cycle

	assign rdata          = st.rdata;
	assign out_freq       = st.freq;
	assign length_reached = st.len_hit;
	assign count_final    = st.fin_hit;
	assign count_interim  = st.int_hit;
	assign irq            = st.irq;

	// swing amplitude and ramp lengths
	always_comb
	begin
		if (st.cfg.base_sel == 16'h0000)
			base_f = {16'h0000, set_freq};
		else
			base_f = {16'h0000, st.cfg.fmax};
		aw      = (base_f * {16'h0000, st.cfg.amp}) / PCT_FULL;
		jmp     = (aw * {16'h0000, st.cfg.jump}) / PCT_FULL;
		per_ms  = {16'h0000, st.cfg.period} * MS_PER_UNIT;
		rise_ms = (per_ms * {16'h0000, st.cfg.rise}) / PCT_FULL;
		fall_ms = per_ms - rise_ms;
		seg_ms  = (st.phase == SLC_RISE) ? rise_ms : fall_ms;
		// zero amplitude or zero period means no swing
		active  = st.cfg.ctrl[CTRL_SWING_EN] && (st.cfg.amp != 16'h0000)
		          && (per_ms != 32'h0000_0000);
		tick    = (st.tick_cnt == 32'(TICK_CYCLES - 1));
		sum     = 20'(signed'({4'h0, set_freq})) + 20'(st.offset);
	end

	// next state
	always_comb
	begin
		nxt_st = st;
		ev     = '0;

		// free-running tick divider
		nxt_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;

		// triangle generator: a serial divider walks the offset at most one
		// unit per cycle, so no wide divider sits in the ramp path
		if (!active)
		begin
			nxt_st.phase  = SLC_RISE;
			nxt_st.t      = 32'h0;
			nxt_st.err    = 32'h0;
			nxt_st.offset = 18'sh0;
		end
		else if (tick && (st.t + 32'h1 >= seg_ms))
		begin
			// ramp ends: turn round and apply the jump step
			nxt_st.t   = 32'h0;
			nxt_st.err = 32'h0;
			case (st.phase)
				SLC_RISE:
				begin
					nxt_st.phase  = SLC_FALL;
					nxt_st.offset = 18'(aw) - 18'(jmp);
				end
				SLC_FALL:
				begin
					nxt_st.phase  = SLC_RISE;
					nxt_st.offset = 18'(jmp) - 18'(aw);
					ev[IRQ_CYCLE] = 1'b1;
				end
				default:
				begin
					nxt_st.phase  = SLC_RISE;
					nxt_st.offset = 18'sh0;
				end
			endcase
		end
		else
		begin
			// ramp slope: 2*aw units across seg_ms ticks
			if (tick)
			begin
				nxt_st.t   = st.t + 32'h1;
				nxt_st.err = st.err + (aw << 1);
			end
			if (st.err >= seg_ms)
			begin
				nxt_st.err = nxt_st.err - seg_ms;
				// signed compares: the offset goes below zero
				if (st.phase == SLC_RISE && st.offset < $signed(18'(aw)))
					nxt_st.offset = st.offset + 18'sh1;
				else if (st.phase == SLC_FALL
				         && st.offset > -$signed(18'(aw)))
					nxt_st.offset = st.offset - 18'sh1;
			end
		end

		// output frequency clamped into the limits
		if (sum > 20'(signed'({4'h0, st.cfg.upper})))
			nxt_st.freq = st.cfg.upper;
		else if (sum < 20'(signed'({4'h0, st.cfg.lower})))
			nxt_st.freq = st.cfg.lower;
		else
			nxt_st.freq = sum[15:0];

		// length: each pulse adds 10, scale is in 0.1 pulses per metre
		nxt_st.len_d = din.len_pulse;
		if (din.len_clear)
		begin
			nxt_st.len_acc = 32'h0;
			nxt_st.length  = 16'h0;
			nxt_st.len_hit = 1'b0;
		end
		else
		begin
			if (din.len_pulse && !st.len_d)
				nxt_st.len_acc = st.len_acc + PPM_STEP;
			// one metre per cycle at most; pulses are far slower
			if (st.cfg.ppm != 16'h0000 && st.len_acc >= {16'h0, st.cfg.ppm}
			    && st.length != 16'hffff)
			begin
				nxt_st.len_acc = nxt_st.len_acc - {16'h0, st.cfg.ppm};
				nxt_st.length  = st.length + 16'h1;
			end
			if (st.length > st.cfg.target)
				nxt_st.len_hit = 1'b1;
		end
		ev[IRQ_LEN] = nxt_st.len_hit && !st.len_hit;

		// counter with final and interim thresholds
		nxt_st.cnt_d = din.cnt_pulse;
		if (din.cnt_clear)
		begin
			nxt_st.count   = 16'h0;
			nxt_st.fin_hit = 1'b0;
			nxt_st.int_hit = 1'b0;
		end
		else
		begin
			// stops once the final threshold is reached
			if (din.cnt_pulse && !st.cnt_d && st.count < st.cfg.final_thr)
				nxt_st.count = st.count + 16'h1;
			if (st.count >= st.cfg.final_thr)
				nxt_st.fin_hit = 1'b1;
			if (st.count >= st.cfg.interim_thr)
				nxt_st.int_hit = 1'b1;
		end
		ev[IRQ_FINAL]   = nxt_st.fin_hit && !st.fin_hit;
		ev[IRQ_INTERIM] = nxt_st.int_hit && !st.int_hit;

		// register writes, measured length and count are read-only
		if (bus.wr)
		begin
			if (bus.addr == ADDR_BASE_SEL)
				nxt_st.cfg.base_sel = {15'h0, bus.wdata[0]};
			else if (bus.addr == ADDR_AMP_PCT)
				nxt_st.cfg.amp = bus.wdata;
			else if (bus.addr == ADDR_JUMP_PCT)
				nxt_st.cfg.jump = bus.wdata;
			else if (bus.addr == ADDR_PERIOD)
				nxt_st.cfg.period = bus.wdata;
			else if (bus.addr == ADDR_RISE_COEF)
				nxt_st.cfg.rise = bus.wdata;
			else if (bus.addr == ADDR_TARGET_LEN)
				nxt_st.cfg.target = bus.wdata;
			else if (bus.addr == ADDR_PPM)
				nxt_st.cfg.ppm = bus.wdata;
			else if (bus.addr == ADDR_FINAL_THR)
				nxt_st.cfg.final_thr = bus.wdata;
			else if (bus.addr == ADDR_INTERIM)
				nxt_st.cfg.interim_thr = bus.wdata;
			else if (bus.addr == ADDR_CTRL)
				nxt_st.cfg.ctrl = {15'h0, bus.wdata[CTRL_SWING_EN]};
			else if (bus.addr == ADDR_IRQ_EN)
				nxt_st.cfg.irq_en = bus.wdata[IRQ_W-1:0];
			else if (bus.addr == ADDR_FREQ_UPPER)
				nxt_st.cfg.upper = bus.wdata;
			else if (bus.addr == ADDR_FREQ_LOWER)
				nxt_st.cfg.lower = bus.wdata;
			else if (bus.addr == ADDR_FREQ_MAX)
				nxt_st.cfg.fmax = bus.wdata;
		end

		// sticky status: a new event beats a clear in the same cycle
		if (bus.wr && bus.addr == ADDR_IRQ_CLR)
			nxt_st.irq_st = (st.irq_st & ~bus.wdata[IRQ_W-1:0]) | ev;
		else
			nxt_st.irq_st = st.irq_st | ev;
		nxt_st.irq = |(nxt_st.irq_st & nxt_st.cfg.irq_en);

		// read data, only in the cycle after the strobe
		nxt_st.rdata = 16'h0;
		if (bus.rd)
		begin
			if (bus.addr == ADDR_BASE_SEL)
				nxt_st.rdata = st.cfg.base_sel;
			else if (bus.addr == ADDR_AMP_PCT)
				nxt_st.rdata = st.cfg.amp;
			else if (bus.addr == ADDR_JUMP_PCT)
				nxt_st.rdata = st.cfg.jump;
			else if (bus.addr == ADDR_PERIOD)
				nxt_st.rdata = st.cfg.period;
			else if (bus.addr == ADDR_RISE_COEF)
				nxt_st.rdata = st.cfg.rise;
			else if (bus.addr == ADDR_TARGET_LEN)
				nxt_st.rdata = st.cfg.target;
			else if (bus.addr == ADDR_MEAS_LEN)
				nxt_st.rdata = st.length;
			else if (bus.addr == ADDR_PPM)
				nxt_st.rdata = st.cfg.ppm;
			else if (bus.addr == ADDR_FINAL_THR)
				nxt_st.rdata = st.cfg.final_thr;
			else if (bus.addr == ADDR_INTERIM)
				nxt_st.rdata = st.cfg.interim_thr;
			else if (bus.addr == ADDR_CTRL)
				nxt_st.rdata = st.cfg.ctrl;
			else if (bus.addr == ADDR_COUNT)
				nxt_st.rdata = st.count;
			else if (bus.addr == ADDR_IRQ_STAT)
				nxt_st.rdata = {12'h0, st.irq_st};
			else if (bus.addr == ADDR_IRQ_EN)
				nxt_st.rdata = {12'h0, st.cfg.irq_en};
			else if (bus.addr == ADDR_FREQ_UPPER)
				nxt_st.rdata = st.cfg.upper;
			else if (bus.addr == ADDR_FREQ_LOWER)
				nxt_st.rdata = st.cfg.lower;
			else if (bus.addr == ADDR_FREQ_MAX)
				nxt_st.rdata = st.cfg.fmax;
			else if (bus.addr == ADDR_OUT_FREQ)
				nxt_st.rdata = st.freq;
		end
	end

	// state register; ce low freezes everything
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st                 <= '0;
			st.phase           <= SLC_RISE;
			st.cfg.base_sel    <= RST_BASE_SEL;
			st.cfg.amp         <= RST_AMP_PCT;
			st.cfg.jump        <= RST_JUMP_PCT;
			st.cfg.period      <= RST_PERIOD;
			st.cfg.rise        <= RST_RISE_COEF;
			st.cfg.target      <= RST_TARGET_LEN;
			st.cfg.ppm         <= RST_PPM;
			st.cfg.final_thr   <= RST_FINAL_THR;
			st.cfg.interim_thr <= RST_INTERIM;
			st.cfg.ctrl        <= RST_CTRL;
			st.cfg.upper       <= RST_FREQ_UPPER;
			st.cfg.lower       <= RST_FREQ_LOWER;
			st.cfg.fmax        <= RST_FREQ_MAX;
		end
		else if (ce)
			st <= nxt_st;
	end

endmodule : slc_swing_length_count

// File: slc_props.sv
`timescale 1ns/1ps
// flag checks seen from the top ports only
module slc_props
	import slc_pkg::*;
(
	input wire logic     clk,            // 50 MHz clock
	input wire logic     srst,           // sync reset, active high
	input wire slc_din_s din,            // discrete terminals
	input wire logic     length_reached, // length flag
	input wire logic     count_final,    // final count flag
	input wire logic     count_interim   // interim count flag
);
	// one domain, so clock and reset are given once
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (srst);

	// flags are sticky: only their clear input drops them
	AST_LEN_HOLD: assert property (length_reached && !din.len_clear
		|=> length_reached) else $error("length flag fell early");
	AST_FIN_HOLD: assert property (count_final && !din.cnt_clear
		|=> count_final) else $error("final flag fell early");
	AST_INT_HOLD: assert property (count_interim && !din.cnt_clear
		|=> count_interim) else $error("interim flag fell early");
	// clear inputs act on the next edge
	AST_LEN_CLR: assert property (din.len_clear |=> !length_reached)
		else $error("length flag survived clear");
	AST_CNT_CLR: assert property (din.cnt_clear
		|=> !count_final && !count_interim) else $error("count flags kept");
	// final implies interim only while the interim threshold is not above final; the block does not refuse a higher interim
	AST_FIN_INT: assert property (count_final |-> count_interim)
		else $error("final flag without interim flag");
	// a count flag only rises shortly after a count pulse
	AST_FIN_ROSE: assert property ($rose(count_final)
		|-> $past(din.cnt_pulse) || $past(din.cnt_pulse, 2)
		|| $past(din.cnt_pulse, 3)) else $error("final flag without pulse");
	AST_INT_ROSE: assert property ($rose(count_interim)
		|-> $past(din.cnt_pulse) || $past(din.cnt_pulse, 2)
		|| $past(din.cnt_pulse, 3)) else $error("interim flag no pulse");
endmodule : slc_props

bind slc_swing_length_count slc_props u_props (.clk(clk), .srst(srst),
	.din(din), .length_reached(length_reached),
	.count_final(count_final), .count_interim(count_interim));

// File: slc_term_model.sv
`timescale 1ns/1ps
// discrete terminal source: one-cycle pulses, level clears
module slc_term_model
	import slc_pkg::*;
(
	input  wire logic clk,      // clock
	input  wire logic fire_len, // send one length pulse
	input  wire logic fire_cnt, // send one count pulse
	input  wire logic clr_len,  // hold length clear
	input  wire logic clr_cnt,  // hold count clear
	output slc_din_s  din       // terminal levels
);
	// terminals idle low before the first edge
	initial din = '0;
	// registered so every edge seen by the block is clean
	always @(posedge clk)
	begin
		din.len_pulse <= fire_len;
		din.cnt_pulse <= fire_cnt;
		din.len_clear <= clr_len;
		din.cnt_clear <= clr_cnt;
	end
endmodule : slc_term_model

// File: slc_swing_length_count_tb.sv
`timescale 1ns/1ps
// self-checking bench, tick shortened to 4 cycles
module slc_swing_length_count_tb
	import slc_pkg::*;
;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	slc_bus_s    bus = '0;
	logic [15:0] set_freq = 16'h03e8; // centre 10.00 Hz
	logic        fire_len = 1'b0;
	logic        fire_cnt = 1'b0;
	logic        clr_len = 1'b0;
	logic        clr_cnt = 1'b0;
	slc_din_s    din;
	logic [15:0] rdata, out_freq, mx, mn, hi, lo, prv;
	logic        length_reached, count_final, count_interim, irq;
	logic        mon = 1'b0;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          t_hi, t_lo, per, rise;

	always #10 clk = ~clk;

	slc_swing_length_count #(.TICK_CYCLES(4)) DUT (.clk(clk), .srst(srst),
		.ce(1'b1), .bus(bus), .rdata(rdata), .set_freq(set_freq), .din(din),
		.out_freq(out_freq), .length_reached(length_reached),
		.count_final(count_final), .count_interim(count_interim), .irq(irq));
	slc_term_model u_term (.clk(clk), .fire_len(fire_len),
		.fire_cnt(fire_cnt), .clr_len(clr_len), .clr_cnt(clr_cnt), .din(din));

	// swing monitor: extremes, peak-to-peak and trough-to-peak times
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		prv <= out_freq;
		if (mon && out_freq > mx)
			mx <= out_freq;
		if (mon && out_freq < mn)
			mn <= out_freq;
		if (mon && out_freq == hi && prv != hi)
		begin
			per <= cyc - t_hi;
			rise <= cyc - t_lo;
			t_hi <= cyc;
		end
		if (mon && out_freq == lo && prv != lo)
			t_lo <= cyc;
	end

	task automatic check(input string nm, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus <= '0;
	endtask : wr

	// read data is valid only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [15:0] e, string nm);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		bus <= '0;
		#1;
		check(nm, rdata, e);
	endtask : rd

	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle

	// one pulse each, low for two cycles between them
	task automatic pulse(input logic ln, input int n);
		repeat (n)
		begin
			@(posedge clk);
			fire_len <= ln;
			fire_cnt <= !ln;
			@(posedge clk);
			fire_len <= 1'b0;
			fire_cnt <= 1'b0;
			@(posedge clk);
		end
		settle();
	endtask : pulse

	task automatic clr(input logic ln);
		@(posedge clk);
		clr_len <= ln;
		clr_cnt <= !ln;
		repeat (2) @(posedge clk);
		clr_len <= 1'b0;
		clr_cnt <= 1'b0;
		settle();
	endtask : clr

	task automatic t_regs;
		logic [20:0] rv [6];
		rv = '{{ADDR_PERIOD, RST_PERIOD}, {ADDR_RISE_COEF, RST_RISE_COEF},
			{ADDR_TARGET_LEN, RST_TARGET_LEN}, {ADDR_FINAL_THR, RST_FINAL_THR},
			{ADDR_INTERIM, RST_INTERIM}, {ADDR_JUMP_PCT, RST_JUMP_PCT}};
		foreach (rv[i])
			rd(rv[i][20:16], rv[i][15:0], "reset value");
		wr(ADDR_MEAS_LEN, 16'hffff);
		rd(ADDR_MEAS_LEN, 16'h0000, "read only");
		rd(5'h1f, 16'h0000, "unmapped");
	endtask : t_regs

	task automatic t_count;
		wr(ADDR_FINAL_THR, 16'h0003);
		wr(ADDR_INTERIM, 16'h0002);
		wr(ADDR_IRQ_EN, 16'h0006);
		pulse(1'b0, 2);
		check("interim", count_interim, 1'b1);
		check("final early", count_final, 1'b0);
		pulse(1'b0, 3);
		check("final", count_final, 1'b1);
		check("irq", irq, 1'b1);
		rd(ADDR_COUNT, 16'h0003, "count stops");
		rd(ADDR_IRQ_STAT, 16'h0006, "status");
		wr(ADDR_IRQ_EN, 16'h0000);
		settle();
		check("irq masked", irq, 1'b0);
		clr(1'b0);
		check("final clr", count_final, 1'b0);
		wr(ADDR_IRQ_CLR, 16'h000f);
		rd(ADDR_IRQ_STAT, 16'h0000, "status clr");
	endtask : t_count

	task automatic t_len;
		wr(ADDR_PPM, 16'h0014);
		wr(ADDR_TARGET_LEN, 16'h0001);
		pulse(1'b1, 2);
		rd(ADDR_MEAS_LEN, 16'h0001, "length");
		check("len equal", length_reached, 1'b0);
		pulse(1'b1, 2);
		check("len over", length_reached, 1'b1);
		clr(1'b1);
		rd(ADDR_MEAS_LEN, 16'h0000, "length clr");
	endtask : t_len

	// period 0.1 s is 100 ticks, 400 cycles here
	task automatic t_swing(input logic [15:0] b, a, r, u, eh, el,
		input int ep, er);
		wr(ADDR_CTRL, 16'h0000);
		wr(ADDR_BASE_SEL, b);
		wr(ADDR_AMP_PCT, a);
		wr(ADDR_RISE_COEF, r);
		wr(ADDR_FREQ_UPPER, u);
		wr(ADDR_PERIOD, 16'h0001);
		hi <= eh;
		lo <= el;
		mx <= 16'h0000;
		mn <= 16'hffff;
		wr(ADDR_CTRL, 16'h0001);
		mon <= 1'b1;
		// long enough for two full periods after the first ramp
		repeat (1200) @(posedge clk);
		mon <= 1'b0;
		#1;
		check("swing max", mx, eh);
		check("swing min", mn, el);
		if (ep > 0)
		begin
			check("period", 16'(per), 16'(ep));
			check("rise", 16'(rise), 16'(er));
		end
	endtask : t_swing

	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_count();
		t_len();
		t_swing(16'h0000, 16'h0064, 16'h01f4, 16'h1388, 16'h044c, 16'h0384,
			400, 200);
		t_swing(16'h0000, 16'h0064, 16'h00fa, 16'h1388, 16'h044c, 16'h0384,
			400, 100);
		t_swing(16'h0001, 16'h0064, 16'h01f4, 16'h0514, 16'h0514, 16'h01f4,
			0, 0);
		t_swing(16'h0000, 16'h0000, 16'h01f4, 16'h1388, 16'h03e8, 16'h03e8,
			0, 0);
		print_verdict();
	end

	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end
endmodule : slc_swing_length_count_tb
